// ### shared/io_mux_pkg.sv
// Constants for the I/O function multiplexer control block
package io_mux_pkg;
    localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK  = 32'h0000_7F77;
    localparam int          AUDIO_DIR_BIT    = 14;
    localparam int          MODEM_SEL_BIT    = 13;
    localparam int          WIDE_RGB_BIT     = 12;
    localparam int          PINSET_B_LSB     = 10;
    localparam int          PINSET_A_LSB     = 8;
    localparam int          CAPTURE_B_LSB    = 4;
    localparam int          CAPTURE_A_LSB    = 0;
    localparam int          VIDEO_W          = 10;
    localparam int          RESET_PULSE_US   = 400;
    localparam int          CLK_MHZ          = 100;
    localparam int          RESET_PULSE_CYC  = RESET_PULSE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        CARD_ONE, CARD_TWO, VERIFIER_ONE, VERIFIER_TWO
    } card_src_t;

    typedef enum logic [2:0] {
        CAP_PORT_ONE, CAP_PORT_TWO, CAP_PORT_THREE, CAP_COMPOSITOR, CAP_LINK_CORE
    } capture_src_t;
endpackage

// ### core/card_pinset_mux.sv
// Routing of one smart-card pin set to one of four card or verifier modules
`timescale 1ns/1ps
module card_pinset_mux (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Selection
    input  wire logic [1:0] source,
    // Module sides, index 0 card one, 1 card two, 2 verifier one, 3 verifier two
    input  wire logic [3:0] mod_cmd,
    input  wire logic [3:0] mod_rst,
    input  wire logic [3:0] mod_clk,
    input  wire logic [3:0] mod_data_out,
    input  wire logic [3:0] mod_data_oe,
    input  wire logic [3:0] mod_aux_out,
    input  wire logic [3:0] mod_aux_oe,
    input  wire logic [3:0] mod_vpp,
    // Pin side
    output logic            pin_cmd,
    output logic            pin_rst,
    output logic            pin_clk,
    output logic            pin_data_out,
    output logic            pin_data_oe,
    output logic            aux_out,
    output logic            aux_oe,
    output logic            vpp_out
);
    wire logic verifier_sel;

    // Verifier codes have the upper bit set
    assign verifier_sel = source[1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_cmd      <= 1'b0;
            pin_rst      <= 1'b0;
            pin_clk      <= 1'b0;
            pin_data_out <= 1'b0;
            pin_data_oe  <= 1'b0;
            aux_out      <= 1'b0;
            aux_oe       <= 1'b0;
            vpp_out      <= 1'b0;
        end else begin
            pin_cmd      <= mod_cmd[source];
            pin_rst      <= mod_rst[source];
            pin_clk      <= mod_clk[source];
            pin_data_out <= mod_data_out[source];
            pin_data_oe  <= mod_data_oe[source];
            aux_out      <= verifier_sel & mod_aux_out[source]; // RULE11
            aux_oe       <= verifier_sel & mod_aux_oe[source]; // RULE11
            vpp_out      <= verifier_sel & mod_vpp[source]; // RULE11
        end
    end
endmodule // card_pinset_mux

// ### core/capture_source_mux.sv
// Source selection for one video capture unit
`timescale 1ns/1ps
module capture_source_mux (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // Selection
    input  wire logic [2:0]                     source,
    // Sources
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] port_one,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] port_two,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] port_three,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] compositor,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] link_core,
    // Capture side
    output logic [io_mux_pkg::VIDEO_W-1:0]      data_out,
    output logic                                source_valid
);
    logic [io_mux_pkg::VIDEO_W-1:0] sel_data;
    logic                           sel_valid;

    always_comb begin
        sel_valid = 1'b1;
        case (source)
            io_mux_pkg::CAP_PORT_ONE:   sel_data = port_one; // RULE6 RULE7
            io_mux_pkg::CAP_PORT_TWO:   sel_data = port_two;
            io_mux_pkg::CAP_PORT_THREE: sel_data = port_three;
            io_mux_pkg::CAP_COMPOSITOR: sel_data = compositor;
            io_mux_pkg::CAP_LINK_CORE:  sel_data = link_core;
            default: begin
                // Undefined codes connect nothing rather than a stale source
                sel_data  = '0; // RULE12
                sel_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out     <= '0;
            source_valid <= 1'b0;
        end else begin
            data_out     <= sel_data;
            source_valid <= sel_valid;
        end
    end
endmodule // capture_source_mux

// ### core/io_function_mux_control.sv
// I/O function multiplexer control register and pin routing
// Functional notes
// RULE1 - Direction bit 14: zero makes audio port output, one makes it input.
// RULE2 - Bit 13 zero routes third UART to pins, one routes modem serial port.
// RULE3 - Bit 12 zero drives second audio output, one drives video bits 23:20.
// RULE4 - Bits 11:10 pick card one, card two, verifier one or two for set B.
// RULE5 - Bits 9:8 pick card one, card two, verifier one or two for set A.
// RULE6 - Bits 6:4 pick second capture unit source, compositor one at code 3.
// RULE7 - Bits 2:0 pick first capture unit source, compositor two at code 3.
// RULE8 - Bits 7 and 3 ignore writes and read zero.
// RULE9 - External reset must be held at least 400 microseconds after power.
// RULE10 - Bits 31 and 15 ignore writes and read zero.
// RULE11 - Verifier selection enables its vpp and aux contacts, card mode disables them.
// RULE12 - Capture codes 101 to 111 connect no source.
`timescale 1ns/1ps
module io_function_mux_control (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // Register port
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [31:0]                         reg_rdata,
    // Audio bidirectional port, data lane
    input  wire logic                           audio_pin_in,
    input  wire logic                           audio_tx_data,
    output logic                                audio_pin_out,
    output logic                                audio_pin_oe,
    output logic                                audio_rx_data,
    // Shared serial pins
    input  wire logic                           third_serial_port_tx,
    input  wire logic                           soft_modem_serial_port_tx,
    output logic                                serial_pin_tx,
    // Shared audio two or wide RGB pins
    input  wire logic [3:0]                     audio_two_out,
    input  wire logic [3:0]                     digital_video_out_hi,
    output logic [3:0]                          shared_av_pins,
    // Card modules, index 0 card one, 1 card two, 2 verifier one, 3 verifier two
    input  wire logic [3:0]                     mod_cmd,
    input  wire logic [3:0]                     mod_rst,
    input  wire logic [3:0]                     mod_clk,
    input  wire logic [3:0]                     mod_data_out,
    input  wire logic [3:0]                     mod_data_oe,
    input  wire logic [3:0]                     mod_aux_out,
    input  wire logic [3:0]                     mod_aux_oe,
    input  wire logic [3:0]                     mod_vpp,
    // Card pin set A
    output logic                                pinset_a_cmd,
    output logic                                pinset_a_rst,
    output logic                                pinset_a_clk,
    output logic                                pinset_a_data_out,
    output logic                                pinset_a_data_oe,
    output logic                                pinset_a_aux_out,
    output logic                                pinset_a_aux_oe,
    output logic                                pinset_a_vpp,
    // Card pin set B
    output logic                                pinset_b_cmd,
    output logic                                pinset_b_rst,
    output logic                                pinset_b_clk,
    output logic                                pinset_b_data_out,
    output logic                                pinset_b_data_oe,
    output logic                                pinset_b_aux_out,
    output logic                                pinset_b_aux_oe,
    output logic                                pinset_b_vpp,
    // Capture sources
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] video_port_one,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] video_port_two,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] video_port_three,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] compositor_one,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] compositor_two,
    input  wire logic [io_mux_pkg::VIDEO_W-1:0] link_core_data,
    // Capture unit feeds
    output logic [io_mux_pkg::VIDEO_W-1:0]      capture_a_data,
    output logic                                capture_a_valid,
    output logic [io_mux_pkg::VIDEO_W-1:0]      capture_b_data,
    output logic                                capture_b_valid
);
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic        audio_in_s1_r;
    logic        audio_in_s2_r;

    wire logic       ctrl_hit;
    wire logic       audio_port_direction_sel;
    wire logic       modem_serial_sel;
    wire logic       wide_rgb_sel;
    wire logic [1:0] card_pinset_b_source;
    wire logic [1:0] card_pinset_a_source;
    wire logic [2:0] capture_b_source;
    wire logic [2:0] capture_a_source;
    wire logic [31:0] rdata_sel;

    assign ctrl_hit = (reg_addr == io_mux_pkg::CTRL_OFFSET);
    // Unused bits never store, so reads of them are zero by construction
    assign ctrl_nxt = (reg_wr && ctrl_hit) ?
                      (reg_wdata & io_mux_pkg::CTRL_WRITE_MASK) : ctrl_r; // RULE8 RULE10
    assign rdata_sel = ctrl_hit ? ctrl_r : 32'h0000_0000;

    assign audio_port_direction_sel = ctrl_r[io_mux_pkg::AUDIO_DIR_BIT];
    assign modem_serial_sel         = ctrl_r[io_mux_pkg::MODEM_SEL_BIT];
    assign wide_rgb_sel             = ctrl_r[io_mux_pkg::WIDE_RGB_BIT];
    assign card_pinset_b_source     = ctrl_r[io_mux_pkg::PINSET_B_LSB +: 2];
    assign card_pinset_a_source     = ctrl_r[io_mux_pkg::PINSET_A_LSB +: 2];
    assign capture_b_source         = ctrl_r[io_mux_pkg::CAPTURE_B_LSB +: 3];
    assign capture_a_source         = ctrl_r[io_mux_pkg::CAPTURE_A_LSB +: 3];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r    <= io_mux_pkg::CTRL_RESET;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            reg_rdata <= reg_rd ? rdata_sel : 32'h0000_0000;
        end
    end

    // Pin input passes two flops; the second alone feeds logic
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            audio_in_s1_r <= 1'b0;
            audio_in_s2_r <= 1'b0;
        end else begin
            audio_in_s1_r <= audio_pin_in;
            audio_in_s2_r <= audio_in_s1_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            audio_pin_out  <= 1'b0;
            audio_pin_oe   <= 1'b0;
            audio_rx_data  <= 1'b0;
            serial_pin_tx  <= 1'b1;
            shared_av_pins <= 4'h0;
        end else begin
            audio_pin_out  <= audio_port_direction_sel ? 1'b0 : audio_tx_data; // RULE1
            audio_pin_oe   <= ~audio_port_direction_sel; // RULE1
            audio_rx_data  <= audio_port_direction_sel & audio_in_s2_r; // RULE1
            serial_pin_tx  <= modem_serial_sel ? soft_modem_serial_port_tx
                                               : third_serial_port_tx; // RULE2
            shared_av_pins <= wide_rgb_sel ? digital_video_out_hi : audio_two_out; // RULE3
        end
    end

    card_pinset_mux u_pinset_a (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .source       (card_pinset_a_source), // RULE5
        .mod_cmd      (mod_cmd),
        .mod_rst      (mod_rst),
        .mod_clk      (mod_clk),
        .mod_data_out (mod_data_out),
        .mod_data_oe  (mod_data_oe),
        .mod_aux_out  (mod_aux_out),
        .mod_aux_oe   (mod_aux_oe),
        .mod_vpp      (mod_vpp),
        .pin_cmd      (pinset_a_cmd),
        .pin_rst      (pinset_a_rst),
        .pin_clk      (pinset_a_clk),
        .pin_data_out (pinset_a_data_out),
        .pin_data_oe  (pinset_a_data_oe),
        .aux_out      (pinset_a_aux_out),
        .aux_oe       (pinset_a_aux_oe),
        .vpp_out      (pinset_a_vpp)
    );

    card_pinset_mux u_pinset_b (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .source       (card_pinset_b_source), // RULE4
        .mod_cmd      (mod_cmd),
        .mod_rst      (mod_rst),
        .mod_clk      (mod_clk),
        .mod_data_out (mod_data_out),
        .mod_data_oe  (mod_data_oe),
        .mod_aux_out  (mod_aux_out),
        .mod_aux_oe   (mod_aux_oe),
        .mod_vpp      (mod_vpp),
        .pin_cmd      (pinset_b_cmd),
        .pin_rst      (pinset_b_rst),
        .pin_clk      (pinset_b_clk),
        .pin_data_out (pinset_b_data_out),
        .pin_data_oe  (pinset_b_data_oe),
        .aux_out      (pinset_b_aux_out),
        .aux_oe       (pinset_b_aux_oe),
        .vpp_out      (pinset_b_vpp)
    );

    capture_source_mux u_capture_a (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .source       (capture_a_source), // RULE7
        .port_one     (video_port_one),
        .port_two     (video_port_two),
        .port_three   (video_port_three),
        .compositor   (compositor_two),
        .link_core    (link_core_data),
        .data_out     (capture_a_data),
        .source_valid (capture_a_valid)
    );

    capture_source_mux u_capture_b (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .source       (capture_b_source), // RULE6
        .port_one     (video_port_one),
        .port_two     (video_port_two),
        .port_three   (video_port_three),
        .compositor   (compositor_one),
        .link_core    (link_core_data),
        .data_out     (capture_b_data),
        .source_valid (capture_b_valid)
    );

    // Reset hold time is the source's duty; a short pulse still resets fully
    // RULE9

    property p_unused_read_zero;
        @(posedge ref_clk) disable iff (rst)
        reg_rd |=> (reg_rdata[31] == 1'b0 && reg_rdata[15] == 1'b0);
    endproperty
    a_unused_read_zero: assert property (p_unused_read_zero) // RULE10
        else $error("unused bits 31 or 15 read nonzero");

    property p_gap_read_zero;
        @(posedge ref_clk) disable iff (rst)
        reg_rd |=> (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0);
    endproperty
    a_gap_read_zero: assert property (p_gap_read_zero) // RULE8
        else $error("unused bits 7 or 3 read nonzero");

    property p_write_readback;
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && ctrl_hit) ##1 (reg_rd && ctrl_hit && !reg_wr) |=>
            reg_rdata == ($past(reg_wdata, 2) & io_mux_pkg::CTRL_WRITE_MASK);
    endproperty
    a_write_readback: assert property (p_write_readback) // RULE8
        else $error("readback differs from masked write");

    property p_audio_dir;
        @(posedge ref_clk) disable iff (rst)
        $stable(audio_port_direction_sel) |=> audio_pin_oe == !$past(audio_port_direction_sel);
    endproperty
    a_audio_dir: assert property (p_audio_dir) // RULE1
        else $error("audio port direction wrong");

    property p_serial_sel;
        @(posedge ref_clk) disable iff (rst)
        modem_serial_sel |=> serial_pin_tx == $past(soft_modem_serial_port_tx);
    endproperty
    a_serial_sel: assert property (p_serial_sel) // RULE2
        else $error("modem serial port not routed");

    property p_uart_sel;
        @(posedge ref_clk) disable iff (rst)
        !modem_serial_sel |=> serial_pin_tx == $past(third_serial_port_tx);
    endproperty
    a_uart_sel: assert property (p_uart_sel) // RULE2
        else $error("third serial port not routed");

    property p_rgb_sel;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> shared_av_pins ==
            ($past(wide_rgb_sel) ? $past(digital_video_out_hi) : $past(audio_two_out));
    endproperty
    a_rgb_sel: assert property (p_rgb_sel) // RULE3
        else $error("shared audio or rgb pins wrong");

    property p_pinset_a;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> pinset_a_cmd == $past(mod_cmd[card_pinset_a_source]);
    endproperty
    a_pinset_a: assert property (p_pinset_a) // RULE5
        else $error("pin set a wrong module");

    property p_pinset_b;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> pinset_b_clk == $past(mod_clk[card_pinset_b_source]);
    endproperty
    a_pinset_b: assert property (p_pinset_b) // RULE4
        else $error("pin set b wrong module");

    property p_card_no_vpp;
        @(posedge ref_clk) disable iff (rst)
        !card_pinset_a_source[1] |=> !pinset_a_vpp && !pinset_a_aux_oe;
    endproperty
    a_card_no_vpp: assert property (p_card_no_vpp) // RULE11
        else $error("verifier contacts active in card mode");

    property p_cap_a;
        @(posedge ref_clk) disable iff (rst)
        capture_a_source == 3'h3 |=> capture_a_data == $past(compositor_two);
    endproperty
    a_cap_a: assert property (p_cap_a) // RULE7
        else $error("capture a compositor source wrong");

    property p_cap_b;
        @(posedge ref_clk) disable iff (rst)
        capture_b_source == 3'h4 |=> capture_b_data == $past(link_core_data);
    endproperty
    a_cap_b: assert property (p_cap_b) // RULE6
        else $error("capture b link source wrong");

    property p_cap_undef;
        @(posedge ref_clk) disable iff (rst)
        capture_a_source > 3'h4 |=> !capture_a_valid && capture_a_data == '0;
    endproperty
    a_cap_undef: assert property (p_cap_undef) // RULE12
        else $error("undefined capture code connected a source");
endmodule // io_function_mux_control

// ### test/tb_io_function_mux_control.sv
// Self-checking testbench for the I/O function multiplexer control block
`timescale 1ns/1ps
module tb_io_function_mux_control;
    localparam int CEILING = io_mux_pkg::RESET_PULSE_CYC + 6000;
    logic        ref_clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        pin_in;
    logic        tx_data;
    logic        pin_out;
    logic        pin_oe;
    logic        rx_data;
    logic        uart_tx;
    logic        modem_tx;
    logic        serial_tx;
    logic [3:0]  audio_two;
    logic [3:0]  video_hi;
    logic [3:0]  av_pins;
    logic [3:0]  mods;
    wire  [7:0]  pa;
    wire  [7:0]  pb;
    logic [9:0]  src [6];
    logic [9:0]  cap_a;
    logic [9:0]  cap_b;
    logic        val_a;
    logic        val_b;
    int          err_total;
    int          checks;
    int          cyc;

    io_function_mux_control io_function_mux_control_inst (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .audio_pin_in(pin_in), .audio_tx_data(tx_data), .audio_pin_out(pin_out),
        .audio_pin_oe(pin_oe), .audio_rx_data(rx_data),
        .third_serial_port_tx(uart_tx), .soft_modem_serial_port_tx(modem_tx),
        .serial_pin_tx(serial_tx), .audio_two_out(audio_two),
        .digital_video_out_hi(video_hi), .shared_av_pins(av_pins),
        .mod_cmd(mods), .mod_rst(mods), .mod_clk(mods), .mod_data_out(mods),
        .mod_data_oe(mods), .mod_aux_out(mods), .mod_aux_oe(mods), .mod_vpp(mods),
        .pinset_a_cmd(pa[7]), .pinset_a_rst(pa[6]), .pinset_a_clk(pa[5]),
        .pinset_a_data_out(pa[4]), .pinset_a_data_oe(pa[3]), .pinset_a_aux_out(pa[2]),
        .pinset_a_aux_oe(pa[1]), .pinset_a_vpp(pa[0]),
        .pinset_b_cmd(pb[7]), .pinset_b_rst(pb[6]), .pinset_b_clk(pb[5]),
        .pinset_b_data_out(pb[4]), .pinset_b_data_oe(pb[3]), .pinset_b_aux_out(pb[2]),
        .pinset_b_aux_oe(pb[1]), .pinset_b_vpp(pb[0]),
        .video_port_one(src[0]), .video_port_two(src[1]), .video_port_three(src[2]),
        .compositor_one(src[3]), .compositor_two(src[4]), .link_core_data(src[5]),
        .capture_a_data(cap_a), .capture_a_valid(val_a),
        .capture_b_data(cap_b), .capture_b_valid(val_b)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard: a stuck run still reaches the verdict
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == CEILING) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_word(reg_rdata, exp, m);
    endtask

    // Write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                         input string m);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge ref_clk);
        reg_rd    <= 1'b0;
        #1;
        chk_word(reg_rdata, exp, m);
    endtask

    // Long enough for the two pin synchroniser stages plus the output register
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_register();
        rd(8'h00, io_mux_pkg::CTRL_RESET, "reset value");
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_7F77, "unused bits");
        wr(8'h04, 32'h0000_0000);
        rd(8'h00, 32'h0000_7F77, "unmapped write");
        rd(8'h04, 32'h0000_0000, "unmapped read");
        wr_rd(8'h00, 32'hA5A5_A5A5, 32'h0000_2525, "back to back");
        wr(8'h00, 32'h0000_0000);
        $display("test register done");
    endtask

    task automatic t_shared();
        for (int s = 0; s < 2; s++) begin
            wr(8'h00, 32'(s) << 14 | 32'(s) << 13 | 32'(s) << 12);
            for (int v = 0; v < 2; v++) begin
                @(posedge ref_clk);
                pin_in    <= v[0];
                tx_data   <= ~v[0];
                uart_tx   <= v[0];
                modem_tx  <= ~v[0];
                audio_two <= 4'hA ^ {4{v[0]}};
                video_hi  <= 4'h6 ^ {4{v[0]}};
                settle();
                chk_word(32'(pin_oe), 32'(s == 0), "audio oe");
                chk_word(32'(pin_out), s == 0 ? 32'(!v[0]) : 32'h0, "audio out");
                chk_word(32'(rx_data), s == 1 ? 32'(v[0]) : 32'h0, "audio in");
                chk_word(32'(serial_tx), 32'(v[0] ^ s[0]), "serial pin");
                chk_word(32'(av_pins), 32'((s == 0 ? 4'hA : 4'h6) ^ {4{v[0]}}), "av");
            end
        end
        $display("test shared pins done");
    endtask

    function automatic logic [7:0] pin_exp(input logic [1:0] c, input logic [3:0] m);
        logic b;
        b = m[c];
        return {{5{b}}, {3{b & c[1]}}};
    endfunction

    task automatic t_cards();
        logic [1:0] cb;
        for (int i = 0; i < 4; i++) begin
            cb = 2'(3 - i);
            wr(8'h00, 32'(cb) << 10 | 32'(i) << 8);
            for (int p = 0; p < 2; p++) begin
                @(posedge ref_clk);
                mods <= p == 0 ? 4'h1 << i : ~(4'h1 << i);
                settle();
                chk_word(32'(pa), 32'(pin_exp(2'(i), mods)), "pin set a");
                chk_word(32'(pb), 32'(pin_exp(cb, mods)), "pin set b");
            end
        end
        $display("test card pin sets done");
    endtask

    task automatic t_capture();
        logic [9:0] ea;
        logic [9:0] eb;
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, 32'(c) << 4 | 32'(7 - c));
            settle();
            ea = (7 - c) < 3 ? src[7 - c] : (7 - c) == 3 ? src[4] : (7 - c) == 4 ? src[5] : 10'h000;
            eb = c < 3 ? src[c] : c == 3 ? src[3] : c == 4 ? src[5] : 10'h000;
            chk_word(32'(cap_a), 32'(ea), "capture a data");
            chk_word(32'(val_a), 32'((7 - c) < 5), "capture a valid");
            chk_word(32'(cap_b), 32'(eb), "capture b data");
            chk_word(32'(val_b), 32'(c < 5), "capture b valid");
        end
        $display("test capture sources done");
    endtask

    // Second reset from a loaded register, held for the full minimum pulse
    task automatic t_reset();
        wr(8'h00, 32'h0000_7F77);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (io_mux_pkg::RESET_PULSE_CYC) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h00, io_mux_pkg::CTRL_RESET, "value after reset");
        settle();
        chk_word(32'(pin_oe), 32'h1, "audio oe after reset");
        chk_word(32'(cap_a), 32'(src[0]), "capture a after reset");
        $display("test reset done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        pin_in = 1'b0;
        tx_data = 1'b0;
        uart_tx = 1'b1;
        modem_tx = 1'b1;
        audio_two = 4'h0;
        video_hi = 4'h0;
        mods = 4'h0;
        src = '{10'h101, 10'h202, 10'h303, 10'h111, 10'h222, 10'h3C4};
        err_total = 0;
        checks = 0;
        cyc = 0;
        // Start-up reset is short; the full minimum pulse is kept in t_reset
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_register();
        t_shared();
        t_cards();
        t_capture();
        t_reset();
        close_out();
    end
endmodule // tb_io_function_mux_control
